// ### logic/tbt_core.sv
// Periodic timebase with APB register slave and interrupt
`timescale 1ns/1ps
`default_nettype none
module tbt_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tbt_pkg::TBT_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Oscillator clock pin and power modes
    input wire logic oscillator_clock_out,
    input wire logic wait_mode,
    input wire logic stop_mode,
    // Interrupt
    output logic irq
);
    import tbt_pkg::*;

    // --------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------
    tbt_state_t st;                                         // Registered state
    tbt_state_t next_st;                                    // Next state
    logic osc_level;                                        // Synchronised oscillator
    logic osc_rise;                                         // One oscillator edge
    logic chain_active;                                     // Chain may advance
    logic src_tick;                                         // divider_source_clock pulse
    logic presc_tick;                                       // Prescaled pulse
    logic [3:0] tap;                                        // Selected tap bit
    logic [TBT_STAGES-1:0] cnt_inc;                         // Counter plus one
    logic tap_rise;                                         // Selected tap rose
    logic low_power;                                        // Register locked out
    logic setup;                                            // APB setup phase
    logic access;                                           // APB access phase
    logic mapped;                                           // Address decodes
    logic refused;                                          // Access refused
    logic wr_ctrl;                                          // Accepted control write
    logic wr_cfg;                                           // Accepted option write
    logic wr_mask;                                          // Accepted mask write
    logic rd_stat;                                          // Accepted status read
    logic ack_wr;                                           // Acknowledge one written
    logic [TBT_NEV-1:0] events;                             // Event pulses this cycle
    logic [7:0] ctrl_view;                                  // Control register image

    // --------------------------------------------------------------
    // Oscillator pin sampling
    // --------------------------------------------------------------
    tbt_sync u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .d_async(oscillator_clock_out),
        .q_sync(osc_level)
    );

    // Edge of the oscillator clock drives the chain, not the bus clock
    assign osc_rise = osc_level && !st.osc_prev;

    // Chain runs in wait; in stop only with the oscillator kept on
    assign chain_active = st.run && (!stop_mode || st.osc_stop_en);

    // --------------------------------------------------------------
    // Optional divide by 128 ahead of the chain
    // --------------------------------------------------------------
    tbt_presc #(
        .DIV(TBT_PRESC_DIV)
    ) u_presc (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clear(!st.run),
        .tick_in(osc_rise && chain_active),
        .tick_out(presc_tick)
    );

    // Source pulse: direct or prescaled
    assign src_tick = st.presc_sel ? presc_tick : (osc_rise && chain_active);

    // --------------------------------------------------------------
    // Tap selection and rollover detection
    // --------------------------------------------------------------
    // Table entry 0 belongs to rate code 000, the slowest tap
    assign tap = TBT_TAP_BIT[st.rate];
    assign cnt_inc = TBT_STAGES'(st.cnt + 1'b1);
    // Tap bit rising: first after half the period, then every period
    assign tap_rise = src_tick && cnt_inc[tap] && !st.cnt[tap];

    // --------------------------------------------------------------
    // APB decode
    // --------------------------------------------------------------
    assign low_power = wait_mode || stop_mode;
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign mapped = (paddr == TBT_OFS_CTRL) || (paddr == TBT_OFS_CFG)
                 || (paddr == TBT_OFS_STAT) || (paddr == TBT_OFS_MASK);
    // Register unreachable in wait and stop
    assign refused = access && (!mapped || low_power);
    assign wr_ctrl = access && pwrite && !low_power && (paddr == TBT_OFS_CTRL);
    assign wr_cfg = access && pwrite && !low_power && (paddr == TBT_OFS_CFG);
    assign wr_mask = access && pwrite && !low_power && (paddr == TBT_OFS_MASK);
    assign rd_stat = access && !pwrite && !low_power && (paddr == TBT_OFS_STAT);
    assign ack_wr = wr_ctrl && pwdata[TBT_B_ACK];

    // Zero wait states, error on unmapped or locked access
    assign pready = 1'b1;
    assign pslverr = refused;
    assign prdata = st.prdata;

    // Event pulses for the sticky status
    always_comb
    begin
        events = '0;
        events[TBT_EV_ROLL] = tap_rise;
        events[TBT_EV_REFUSED] = refused;
    end

    // Control image; acknowledge always reads zero
    always_comb
    begin
        ctrl_view = 8'h00;
        ctrl_view[TBT_B_FLAG] = st.flag;
        ctrl_view[TBT_B_RATE +: 3] = st.rate;
        ctrl_view[TBT_B_ACK] = 1'b0;
        ctrl_view[TBT_B_IRQEN] = st.irq_en;
        ctrl_view[TBT_B_RUN] = st.run;
    end

    // Level interrupt: pending flag or unmasked sticky event
    assign irq = (st.flag && st.irq_en) || |(st.status & st.mask);

    // --------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.osc_prev = osc_level;
        // Control fields; rate taken as written
        if (wr_ctrl)
        begin
            next_st.run = pwdata[TBT_B_RUN];
            next_st.irq_en = pwdata[TBT_B_IRQEN];
            next_st.rate = pwdata[TBT_B_RATE +: 3];
        end
        // Option bits
        if (wr_cfg)
        begin
            next_st.presc_sel = pwdata[TBT_B_PRESC];
            next_st.osc_stop_en = pwdata[TBT_B_OSCSTOP];
        end
        // Mask register
        if (wr_mask)
            next_st.mask = pwdata[TBT_NEV-1:0];
        // Divider chain: zero while off, counts from zero when on
        if (!next_st.run)
            next_st.cnt = TBT_CNT_RST;
        else if (src_tick)
            next_st.cnt = cnt_inc;
        // Pending flag: rollover wins over acknowledge
        if (tap_rise)
            next_st.flag = 1'b1;
        else if (ack_wr)
            next_st.flag = 1'b0;
        // Sticky status: read clears, new event wins
        if (rd_stat)
            next_st.status = events;
        else
            next_st.status = st.status | events;
        // Read data captured in the setup phase
        if (setup)
        begin
            case (paddr)
                TBT_OFS_CTRL: next_st.prdata = {24'h000000, ctrl_view};
                TBT_OFS_CFG:
                begin
                    next_st.prdata = 32'h00000000;
                    next_st.prdata[TBT_B_PRESC] = st.presc_sel;
                    next_st.prdata[TBT_B_OSCSTOP] = st.osc_stop_en;
                end
                // Include this cycle's events so a read never loses one
                TBT_OFS_STAT: next_st.prdata = {30'h00000000, st.status | events};
                TBT_OFS_MASK: next_st.prdata = {30'h00000000, st.mask};
                default: next_st.prdata = 32'h00000000;
            endcase
            if (low_power)
                next_st.prdata = 32'h00000000;
        end
    end

    // --------------------------------------------------------------
    // State register; reset clears both enables
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.rate <= TBT_RATE_RST;
            st.cnt <= TBT_CNT_RST;
        end
        else
            st <= next_st;
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    // Accepted acknowledge write
    sequence s_ack_write;
        access && pwrite && !low_power && (paddr == TBT_OFS_CTRL)
            && pwdata[TBT_B_ACK];
    endsequence

    // Enable written from off to on
    sequence s_enable;
        !st.run ##1 st.run;
    endsequence

    a_cnt_held_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !st.run |-> st.cnt == TBT_CNT_RST)
        else $error("counter not zero while disabled");

    a_cnt_starts_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_enable |-> st.cnt == TBT_CNT_RST ##1 (st.cnt <= 15'h0001))
        else $error("counter did not start from zero");

    a_cnt_advance: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (st.run && src_tick && !wr_ctrl) |=> st.cnt == $past(cnt_inc))
        else $error("counter did not advance on source pulse");

    a_flag_on_tap: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tap_rise |=> st.flag && ctrl_view[TBT_B_FLAG])
        else $error("pending flag not set on tap rollover");

    a_irq_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (st.flag && st.irq_en) |-> irq)
        else $error("interrupt missing while flag and enable set");

    a_ack_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (s_ack_write ##0 !tap_rise) |=> !st.flag)
        else $error("acknowledge did not clear pending flag");

    a_ack_reads_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (access && !pwrite && paddr == TBT_OFS_CTRL) |-> !prdata[TBT_B_ACK])
        else $error("acknowledge bit read back as one");

    a_first_half: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (tap_rise && st.rate == 3'h7) |-> st.cnt[2:0] == 3'h3)
        else $error("tap rose at wrong counter value");

    a_wait_locked: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (access && wait_mode) |-> pslverr ##1 $stable(st.run))
        else $error("register reachable in wait mode");

    a_stop_frozen: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (stop_mode && !st.osc_stop_en && st.run) |-> !src_tick)
        else $error("chain advanced in stop without oscillator");

    a_reset_clear: assert property (@(posedge clk_sys)
        $fell(sys_rst) |-> !st.run && !st.irq_en && !irq)
        else $error("enables not cleared by reset");

    // Rollover always lands in the sticky status, even under a read
    a_status_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
        events[TBT_EV_ROLL] |=> st.status[TBT_EV_ROLL])
        else $error("rollover event lost from status");

    // Refused write leaves rate, irq enable, prescale select and mask alone
    a_refused_inert: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (access && pwrite && low_power) |=> $stable(st.rate) && $stable(st.irq_en)
            && $stable(st.presc_sel) && $stable(st.mask))
        else $error("refused write changed a register");

    // Refused access is recorded as a sticky event
    a_refused_event: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (access && low_power) |=> st.status[TBT_EV_REFUSED])
        else $error("refused access not recorded");

    // Disabled chain never rolls over
    a_off_no_rise: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !st.run |-> !tap_rise)
        else $error("rollover while disabled");

    // Slowest code taps the top stage
    a_tap_slowest: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (tap_rise && st.rate == 3'h0) |-> st.cnt[13:0] == 14'h3FFF)
        else $error("slowest rate rose at wrong count");

    // Source pulses only on an oscillator edge
    a_src_on_edge: assert property (@(posedge clk_sys) disable iff (sys_rst)
        src_tick |-> osc_rise)
        else $error("source pulse without oscillator edge");

    // Interrupt drops once neither source is left
    a_irq_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!(st.flag && st.irq_en) && !(|(st.status & st.mask))) |-> !irq)
        else $error("interrupt without a pending source");

endmodule
`default_nettype wire

// ### logic/tbt_pkg.sv
// Shared constants and the state type of the periodic timebase block
//
// Behaviour
// - Counter held at zero while disabled
// - Counter counts up from zero once enabled
// - Rollover at selected tap sets pending flag
// - Interrupt while flag set and irq enabled
// - Acknowledge one clears flag, reads zero
// - First event half period, then exact period
// - Rate codes give eight ratios 32768 down to 8
// - Extra prescale multiplies every ratio by 128
// - Fifteen divider stages, eight selectable taps
// - Chain clocked by oscillator clock, not bus
// - Wait mode keeps counting, register inaccessible
// - Stop mode runs only with oscillator enabled
// - Reset clears enable and interrupt enable
package tbt_pkg;

    // --------------------------------------------------------------
    // Bus geometry and register offsets
    // --------------------------------------------------------------
    localparam int TBT_AW = 8;                              // Byte address width
    localparam logic [7:0] TBT_OFS_CTRL = 8'h00;            // timebase_control
    localparam logic [7:0] TBT_OFS_CFG = 8'h04;             // Option bits
    localparam logic [7:0] TBT_OFS_STAT = 8'h08;            // Sticky events
    localparam logic [7:0] TBT_OFS_MASK = 8'h0C;            // Event mask

    // --------------------------------------------------------------
    // timebase_control field positions
    // --------------------------------------------------------------
    localparam int TBT_B_FLAG = 7;                          // Pending flag, read only
    localparam int TBT_B_RATE = 4;                          // Rate select, bits 6..4
    localparam int TBT_B_ACK = 3;                           // Acknowledge, write only
    localparam int TBT_B_IRQEN = 2;                         // Interrupt enable
    localparam int TBT_B_RUN = 1;                           // Run enable

    // --------------------------------------------------------------
    // Option register and event status positions
    // --------------------------------------------------------------
    localparam int TBT_B_PRESC = 0;                         // Extra divide by 128
    localparam int TBT_B_OSCSTOP = 1;                       // Oscillator kept in stop
    localparam int TBT_EV_ROLL = 0;                         // Tap rollover event
    localparam int TBT_EV_REFUSED = 1;                      // Access refused event
    localparam int TBT_NEV = 2;                             // Number of events

    // --------------------------------------------------------------
    // Divider chain geometry
    // --------------------------------------------------------------
    localparam int TBT_STAGES = 15;                         // Divider stages
    localparam int TBT_PRESC_DIV = 128;                     // Extra prescale ratio
    // Tap bit per rate code; ratio is two to the (bit + 1)
    localparam logic [7:0][3:0] TBT_TAP_BIT = {
        4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hC, 4'hE
    };

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [2:0] TBT_RATE_RST = 3'h0;             // Slowest tap
    localparam logic [TBT_STAGES-1:0] TBT_CNT_RST = 15'h0000; // Cleared chain

    // Whole state of the timebase core
    typedef struct packed {
        logic run;                                          // timebase_run_enable
        logic irq_en;                                       // timebase_irq_enable
        logic [2:0] rate;                                   // rate_select_bits
        logic flag;                                         // timebase_pending_flag
        logic [TBT_STAGES-1:0] cnt;                         // Divider chain
        logic presc_sel;                                    // extra_prescale_select
        logic osc_stop_en;                                  // oscillator_in_stop_enable
        logic [TBT_NEV-1:0] status;                         // Sticky events
        logic [TBT_NEV-1:0] mask;                           // Event mask
        logic [31:0] prdata;                                // Read data
        logic osc_prev;                                     // Oscillator level last cycle
    } tbt_state_t;

endpackage

// ### logic/tbt_presc.sv
// Extra prescaler: one output pulse per DIV input pulses
`timescale 1ns/1ps
`default_nettype none
module tbt_presc #(
    parameter int DIV = tbt_pkg::TBT_PRESC_DIV
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control and pulses
    input wire logic clear,
    input wire logic tick_in,
    output logic tick_out
);
    import tbt_pkg::*;

    localparam int W = $clog2(DIV);                         // Counter width
    localparam logic [W-1:0] LAST = W'(DIV - 1);            // Terminal count

    // Input pulse count
    logic [W-1:0] count;

    // Output pulse on the last input pulse of each group
    assign tick_out = tick_in && (count == LAST);

    // --------------------------------------------------------------
    // Counting, cleared with the chain
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            count <= '0;
        else if (clear)
            count <= '0;
        else if (tick_in)
            count <= (count == LAST) ? '0 : W'(count + 1'b1);
    end

endmodule
`default_nettype wire

// ### logic/tbt_sync.sv
// Two-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module tbt_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Level in and out
    input wire logic d_async,
    output logic q_sync
);

    // Capture and settle stages
    logic stage1;

    // --------------------------------------------------------------
    // Two flip-flops in series
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stage1 <= 1'b0;
            q_sync <= 1'b0;
        end
        else
        begin
            stage1 <= d_async;
            q_sync <= stage1;
        end
    end

endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the periodic timebase block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tbt_pkg::*;

    // ----------------------------------------
    // Clock, reset and design ports
    // ----------------------------------------
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [TBT_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic osc = 1'b0;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic irq;
    // Bench bookkeeping
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic er;
    int div [8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};

    // Clock of 10 ns period
    always #5 clk_sys = ~clk_sys;

    // Device under test
    tbt_core DUT (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .oscillator_clock_out(osc),
        .wait_mode(wait_mode),
        .stop_mode(stop_mode),
        .irq(irq)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Verdict and end of run
    task end_sim;
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Compare one value
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; result in rd and er
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Source ticks, two cycles high and two low, then settle
    task ticks(input int n);
        repeat (n)
        begin
            osc <= 1'b1;
            repeat (2) @(posedge clk_sys);
            osc <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
        repeat (4) @(posedge clk_sys);
    endtask

    // Read control and compare the pending flag
    task flag_is(input logic e);
        apb(1'b0, TBT_OFS_CTRL, 32'h0);
        chk("pending flag", {31'h0, e}, {31'h0, rd[TBT_B_FLAG]});
    endtask

    // Compare the interrupt once a write has settled
    task irq_is(input logic e);
        @(negedge clk_sys);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask

    // Timeout guard
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc > 80000)
        begin
            errors++;
            end_sim();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // Reset values of all registers
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        // Ack and bit 0 read zero, rest read back
        apb(1'b1, TBT_OFS_CTRL, 32'h7D);
        apb(1'b0, TBT_OFS_CTRL, 32'h0);
        chk("control readback", 32'h74, rd);
        // Half then full period for codes 1 to 7; code 0 is too slow here
        for (int c = 1; c < 8; c++)
        begin
            apb(1'b1, TBT_OFS_CTRL, 32'(c * 16 + 8));
            ticks(3);
            apb(1'b1, TBT_OFS_CTRL, 32'(c * 16 + 6));
            ticks(div[c] / 2 - 1);
            flag_is(1'b0);
            ticks(1);
            flag_is(1'b1);
            chk("irq", 32'h1, {31'h0, irq});
            apb(1'b1, TBT_OFS_CTRL, 32'(c * 16 + 14));
            flag_is(1'b0);
            ticks(div[c] - 1);
            flag_is(1'b0);
            ticks(1);
            flag_is(1'b1);
            apb(1'b1, TBT_OFS_CTRL, 32'(c * 16));
        end
        // Writing zero to ack leaves the flag
        apb(1'b1, TBT_OFS_CTRL, 32'h76);
        flag_is(1'b1);
        // Interrupt enable off hides the flag
        apb(1'b1, TBT_OFS_CTRL, 32'h72);
        irq_is(1'b0);
        // Masked status drives irq, read clears it
        apb(1'b1, TBT_OFS_MASK, 32'h1);
        irq_is(1'b1);
        apb(1'b0, TBT_OFS_STAT, 32'h0);
        chk("status", 32'h1, rd);
        irq_is(1'b0);
        apb(1'b0, TBT_OFS_STAT, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'b1, TBT_OFS_MASK, 32'h0);
        // Wait mode locks the register, chain runs on
        apb(1'b1, TBT_OFS_CTRL, 32'h78);
        apb(1'b1, TBT_OFS_CTRL, 32'h72);
        wait_mode <= 1'b1;
        apb(1'b0, TBT_OFS_CTRL, 32'h0);
        chk("wait lockout", 32'h1, {31'h0, er});
        chk("wait read data", 32'h0, rd);
        ticks(4);
        wait_mode <= 1'b0;
        flag_is(1'b1);
        apb(1'b0, TBT_OFS_STAT, 32'h0);
        chk("status", 32'h3, rd);
        // Stop mode without oscillator option halts the chain
        apb(1'b1, TBT_OFS_CTRL, 32'h78);
        apb(1'b1, TBT_OFS_CTRL, 32'h72);
        stop_mode <= 1'b1;
        apb(1'b1, TBT_OFS_CTRL, 32'h0);
        chk("stop lockout", 32'h1, {31'h0, er});
        ticks(4);
        stop_mode <= 1'b0;
        flag_is(1'b0);
        // Stop mode with oscillator option keeps counting
        apb(1'b1, TBT_OFS_CFG, 32'h2);
        apb(1'b1, TBT_OFS_CTRL, 32'h78);
        apb(1'b1, TBT_OFS_CTRL, 32'h72);
        stop_mode <= 1'b1;
        ticks(4);
        stop_mode <= 1'b0;
        flag_is(1'b1);
        // Extra prescale scales the fastest rate by 128
        apb(1'b1, TBT_OFS_CFG, 32'h1);
        apb(1'b1, TBT_OFS_CTRL, 32'h78);
        apb(1'b1, TBT_OFS_CTRL, 32'h72);
        ticks(511);
        flag_is(1'b0);
        ticks(1);
        flag_is(1'b1);
        // Reset in mid-run clears both enables
        apb(1'b1, TBT_OFS_CTRL, 32'h76);
        irq_is(1'b1);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, TBT_OFS_CTRL, 32'h0);
        chk("reset value", 32'h0, rd);
        irq_is(1'b0);
        // Stopped before wait, the chain stays quiet
        apb(1'b1, TBT_OFS_CTRL, 32'h70);
        wait_mode <= 1'b1;
        ticks(8);
        wait_mode <= 1'b0;
        flag_is(1'b0);
        // Unmapped address is refused
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        end_sim();
    end
endmodule
`default_nettype wire
